/* design/asi_defs.svh */
// Register offsets, field positions, reset values and bit timing.
// Assumes a 32-bit APB slave decoding the low eight address bits.
`ifndef ASI_DEFS_SVH
`define ASI_DEFS_SVH

// ********************************
// Register byte offsets
// ********************************
`define ASI_OFF_CTRL   8'h00
`define ASI_OFF_STAT   8'h04
`define ASI_OFF_DATA   8'h08
`define ASI_OFF_BAUD   8'h0C
`define ASI_OFF_MASK   8'h10

// ********************************
// Control bits
// ********************************
`define ASI_C_RXEN     0
`define ASI_C_TXEN     1
`define ASI_C_RXIE     2
`define ASI_C_TXIE     3
`define ASI_C_TXEI     4
`define ASI_C_GRPEN    5
`define ASI_C_PINSEL   6
`define ASI_C_PAREN    7
`define ASI_CTRL_W     8
`define ASI_CTRL_RST   8'h00

// ********************************
// Status bits (mask uses the same layout)
// ********************************
`define ASI_S_RXP      0
`define ASI_S_TXP      1
`define ASI_S_TX_END_FLAG     2
`define ASI_S_OVR      3
`define ASI_S_FRM      4
`define ASI_S_PER      5
`define ASI_S_GRP      6
`define ASI_STAT_W     7
`define ASI_MASK_RST   7'h00

// ********************************
// Bit timing: sixteen ticks per bit
// ********************************
`define ASI_TICK_LAST  4'hF
`define ASI_TICK_MID   4'h7
`define ASI_BIT_LAST   3'h7
`define ASI_BAUD_RST   16'h0001

`endif

/* design/asi_pkg.sv */
// Types shared by the serial channel: transmit and receive state codes.
// Assumes nothing of its surroundings.
package asi_pkg;

  // ********************************
  // Transmit sequencer states
  // ********************************
  typedef enum logic [2:0] {
    ASI_TX_IDLE  = 3'b000,
    ASI_TX_START = 3'b001,
    ASI_TX_DATA  = 3'b010,
    ASI_TX_PAR   = 3'b011,
    ASI_TX_STOP  = 3'b100
  } asi_tx_st_t;

  // ********************************
  // Receive sequencer states
  // ********************************
  typedef enum logic [2:0] {
    ASI_RX_IDLE  = 3'b000,
    ASI_RX_START = 3'b001,
    ASI_RX_DATA  = 3'b010,
    ASI_RX_PAR   = 3'b011,
    ASI_RX_STOP  = 3'b100
  } asi_rx_st_t;

endpackage

/* design/asi_tick_gen.sv */
// Oversampling tick divider: one-cycle enable every div_in + 1 clocks.
// Assumes div_in is held stable by software while the channel runs.
`timescale 1ns/1ps
module asi_tick_gen (
  input  wire logic        clk_sys_in,  // System clock
  input  wire logic        sys_rst_in,  // Async reset, high
  input  wire logic [15:0] div_in,      // Reload value
  output logic             tick_out     // One-cycle enable
);

  // ********************************
  // Divider counter
  // ********************************
  logic [15:0] cnt_r;  // Cycles since last tick

  // Count up, wrap and pulse at the reload value
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_r    <= 16'h0000;
      tick_out <= 1'b0;
    end else if (cnt_r >= div_in) begin
      cnt_r    <= 16'h0000;
      tick_out <= 1'b1;
    end else begin
      cnt_r    <= cnt_r + 16'h0001;
      tick_out <= 1'b0;
    end
  end

endmodule

/* design/asi_serial_channel.sv */
// Asynchronous serial channel with APB registers and request flags.
// Assumes an APB master on clk_sys_in and an interrupt controller that
// pulses the ack inputs when it takes a request.
//
// Behaviour
// - Receive-full flag clears when interrupt taken
// - Transmit-empty flag clears when interrupt taken
// - Receive errors drive grouped status and request
// - Overrun, framing, parity flags set separately
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "asi_defs.svh"
module asi_serial_channel
  import asi_pkg::*;
(
  input  wire logic        clk_sys_in,           // System clock, 125 MHz
  input  wire logic        sys_rst_in,           // Async reset, high
  input  wire logic        psel_in,              // APB select
  input  wire logic        penable_in,           // APB enable
  input  wire logic        pwrite_in,            // APB direction
  input  wire logic [7:0]  paddr_in,             // APB byte address
  input  wire logic [31:0] pwdata_in,            // APB write data
  output logic [31:0]      prdata_out,           // APB read data
  output logic             pready_out,           // APB ready
  output logic             pslverr_out,          // APB error
  input  wire logic        rx_pin_in,            // Serial input pin
  output logic             tx_pin_out,           // Serial output pin
  input  wire logic        rx_full_irq_ack_in,   // Receive request taken
  input  wire logic        tx_empty_irq_ack_in,  // Transmit request taken
  output logic             rx_full_irq_out,      // Receive-full request
  output logic             tx_empty_irq_out,     // Transmit-empty request
  output logic             rx_error_irq_out,     // Grouped error request
  output logic             tx_end_irq_out,       // Transmit-end request
  output logic             irq_out               // Masked summary level
);

  // ********************************
  // Declarations
  // ********************************
  logic [7:0]  serial_control_reg;          // Enables and pin select
  logic [6:0]  mask_r;                      // Summary interrupt mask
  logic [15:0] baud_r;                      // Tick divider reload
  logic        tick;                        // Sixteen per bit
  logic        rxp_r, txp_r;                // Pending request flags
  logic        ovr_r, frm_r, per_r, grp_r;  // Error flags and group
  logic        tx_end_flag_r;                      // Transmit-end flag
  logic        setup, wr_acc, rd_acc;       // APB phases
  logic        wr_stat, wr_data, rd_data;   // Register strobes
  logic [6:0]  stat;                        // Status view
  logic [7:0]  tx_data_reg, rx_data_reg;    // Data holding registers
  logic        tx_full_r, rx_has_r;         // Holding occupancy
  logic        txen_d1_r;                   // Transmit enable, delayed
  logic        rx_s1_r, rx_s2_r, rx_s3_r;   // Pin synchroniser
  logic        rx_q_r;                      // Filtered pin level
  asi_tx_st_t  tx_st_r;                     // Transmit state
  asi_rx_st_t  rx_st_r;                     // Receive state
  logic [3:0]  tx_cnt_r, rx_cnt_r;          // Tick counters
  logic [2:0]  tx_bit_r, rx_bit_r;          // Bit counters
  logic [7:0]  tx_sh_r, rx_sh_r;            // Shift registers
  logic        tx_line_r, rx_par_r;         // Line level, parity bit
  logic        tx_load, tx_done, rx_fin;    // Sequencer events
  logic        rx_set, tx_set, rx_stop_ok;  // Flag set terms

  assign setup   = psel_in & ~penable_in;
  assign wr_acc  = psel_in & penable_in & pready_out & pwrite_in;
  assign rd_acc  = psel_in & penable_in & pready_out & ~pwrite_in;
  assign wr_stat = wr_acc & (paddr_in == `ASI_OFF_STAT);
  assign wr_data = wr_acc & (paddr_in == `ASI_OFF_DATA);
  assign rd_data = rd_acc & (paddr_in == `ASI_OFF_DATA);
  assign stat    = {grp_r, per_r, frm_r, ovr_r, tx_end_flag_r, txp_r, rxp_r};

  // ********************************
  // Bit tick divider
  // ********************************
  asi_tick_gen u_tick (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .div_in     (baud_r),
    .tick_out   (tick)
  );

  // ********************************
  // APB slave: one wait-free access phase
  // ********************************
  // Ready and read data are prepared in the setup cycle
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= setup;
      pslverr_out <= 1'b0;
      if (setup) begin
        case (paddr_in)
          `ASI_OFF_CTRL: prdata_out <= {24'h000000, serial_control_reg};
          `ASI_OFF_STAT: prdata_out <= {25'h0000000, stat};
          `ASI_OFF_DATA: prdata_out <= {24'h000000, rx_data_reg};
          `ASI_OFF_BAUD: prdata_out <= {16'h0000, baud_r};
          `ASI_OFF_MASK: prdata_out <= {25'h0000000, mask_r};
          default: begin
            prdata_out  <= 32'h0000_0000;  // Unmapped reads zero
            pslverr_out <= 1'b1;
          end
        endcase
      end
    end
  end

  // Software-written configuration
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      serial_control_reg <= `ASI_CTRL_RST;
      mask_r             <= `ASI_MASK_RST;
      baud_r             <= `ASI_BAUD_RST;
    end else if (wr_acc) begin
      case (paddr_in)
        `ASI_OFF_CTRL: serial_control_reg <= pwdata_in[`ASI_CTRL_W-1:0];
        `ASI_OFF_BAUD: baud_r <= pwdata_in[15:0];
        `ASI_OFF_MASK: mask_r <= pwdata_in[`ASI_STAT_W-1:0];
        default: ;  // Others have no stored configuration
      endcase
    end
  end

  // ********************************
  // Receive pin synchroniser
  // ********************************
  // Level is accepted once the last two stages agree
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_s3_r <= 1'b1;
      rx_q_r  <= 1'b1;
    end else begin
      rx_s1_r <= rx_pin_in;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
      if (rx_s2_r == rx_s3_r) begin
        rx_q_r <= rx_s3_r;
      end
    end
  end

  // ********************************
  // Transmit sequencer
  // ********************************
  assign tx_load = (tx_st_r == ASI_TX_IDLE) & tx_full_r & serial_control_reg[`ASI_C_TXEN];
  assign tx_done = (tx_st_r == ASI_TX_STOP) & tick & (tx_cnt_r == `ASI_TICK_LAST);

  // Frame: start, eight data bits LSB first, optional even parity, stop
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_st_r   <= ASI_TX_IDLE;
      tx_cnt_r  <= 4'h0;
      tx_bit_r  <= 3'h0;
      tx_sh_r   <= 8'h00;
      tx_line_r <= 1'b1;
    end else if (tx_load) begin
      tx_st_r   <= ASI_TX_START;
      tx_sh_r   <= tx_data_reg;
      tx_cnt_r  <= 4'h0;
      tx_line_r <= 1'b0;
    end else if (tick && tx_st_r != ASI_TX_IDLE) begin
      tx_cnt_r <= tx_cnt_r + 4'h1;
      if (tx_cnt_r == `ASI_TICK_LAST) begin
        case (tx_st_r)
          ASI_TX_START: begin
            tx_st_r   <= ASI_TX_DATA;
            tx_bit_r  <= 3'h0;
            tx_line_r <= tx_sh_r[0];
          end
          ASI_TX_DATA: begin
            tx_bit_r <= tx_bit_r + 3'h1;
            if (tx_bit_r != `ASI_BIT_LAST) begin
              tx_line_r <= tx_sh_r[tx_bit_r + 3'h1];
            end else if (serial_control_reg[`ASI_C_PAREN]) begin
              tx_st_r   <= ASI_TX_PAR;
              tx_line_r <= ^tx_sh_r;
            end else begin
              tx_st_r   <= ASI_TX_STOP;
              tx_line_r <= 1'b1;
            end
          end
          ASI_TX_PAR: begin
            tx_st_r   <= ASI_TX_STOP;
            tx_line_r <= 1'b1;
          end
          default: begin
            tx_st_r   <= ASI_TX_IDLE;  // Stop bit finished
            tx_line_r <= 1'b1;
          end
        endcase
      end
    end
  end

  // Transmit holding register and transmit-end flag
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_data_reg <= 8'h00;
      tx_full_r   <= 1'b0;
      tx_end_flag_r      <= 1'b1;
    end else begin
      if (wr_data) begin
        tx_data_reg <= pwdata_in[7:0];
        tx_full_r   <= 1'b1;
        tx_end_flag_r      <= 1'b0;
      end else if (tx_load) begin
        tx_full_r <= 1'b0;
      end else if (tx_done && !tx_full_r) begin
        tx_end_flag_r <= 1'b1;
      end
    end
  end

  // ********************************
  // Receive sequencer
  // ********************************
  assign rx_fin     = (rx_st_r == ASI_RX_STOP) & tick & (rx_cnt_r == `ASI_TICK_LAST);
  assign rx_stop_ok = rx_q_r;

  // Start edge, mid-bit check, then one sample per sixteen ticks
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_st_r  <= ASI_RX_IDLE;
      rx_cnt_r <= 4'h0;
      rx_bit_r <= 3'h0;
      rx_sh_r  <= 8'h00;
      rx_par_r <= 1'b0;
    end else if (!serial_control_reg[`ASI_C_RXEN]) begin
      rx_st_r <= ASI_RX_IDLE;
    end else if (rx_st_r == ASI_RX_IDLE) begin
      if (!rx_q_r) begin
        rx_st_r  <= ASI_RX_START;
        rx_cnt_r <= 4'h0;
      end
    end else if (tick) begin
      rx_cnt_r <= rx_cnt_r + 4'h1;
      case (rx_st_r)
        ASI_RX_START: begin
          if (rx_cnt_r == `ASI_TICK_MID) begin
            rx_cnt_r <= 4'h0;
            rx_bit_r <= 3'h0;
            rx_st_r  <= rx_q_r ? ASI_RX_IDLE : ASI_RX_DATA;  // Glitch reject
          end
        end
        ASI_RX_DATA: begin
          if (rx_cnt_r == `ASI_TICK_LAST) begin
            rx_sh_r  <= {rx_q_r, rx_sh_r[7:1]};
            rx_bit_r <= rx_bit_r + 3'h1;
            if (rx_bit_r == `ASI_BIT_LAST) begin
              rx_st_r <= serial_control_reg[`ASI_C_PAREN] ? ASI_RX_PAR : ASI_RX_STOP;
            end
          end
        end
        ASI_RX_PAR: begin
          if (rx_cnt_r == `ASI_TICK_LAST) begin
            rx_par_r <= rx_q_r;
            rx_st_r  <= ASI_RX_STOP;
          end
        end
        default: begin
          if (rx_cnt_r == `ASI_TICK_LAST) begin
            rx_st_r <= ASI_RX_IDLE;  // Stop bit sampled
          end
        end
      endcase
    end
  end

  // Receive holding register; a read empties it
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_data_reg <= 8'h00;
      rx_has_r    <= 1'b0;
    end else if (rx_fin && (!rx_has_r || rd_data)) begin
      rx_data_reg <= rx_sh_r;
      rx_has_r    <= 1'b1;
    end else if (rd_data) begin
      rx_has_r <= 1'b0;
    end
  end

  // ********************************
  // Request and error flags (set wins over clear)
  // ********************************
  assign rx_set = rx_fin & serial_control_reg[`ASI_C_RXIE];
  assign tx_set = serial_control_reg[`ASI_C_TXIE] & serial_control_reg[`ASI_C_TXEN]
                & (tx_load | ~txen_d1_r);

  // Pending flags drop when the controller takes them
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rxp_r     <= 1'b0;
      txp_r     <= 1'b0;
      txen_d1_r <= 1'b0;
    end else begin
      txen_d1_r <= serial_control_reg[`ASI_C_TXEN];
      rxp_r <= rx_set | (rxp_r & ~rx_full_irq_ack_in
               & ~(wr_stat & pwdata_in[`ASI_S_RXP]));
      txp_r <= tx_set | (txp_r & ~tx_empty_irq_ack_in
               & ~(wr_stat & pwdata_in[`ASI_S_TXP]));
    end
  end

  // Separate sticky error flags, written one to clear
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ovr_r <= 1'b0;
      frm_r <= 1'b0;
      per_r <= 1'b0;
    end else begin
      ovr_r <= (rx_fin & rx_has_r & ~rd_data)
               | (ovr_r & ~(wr_stat & pwdata_in[`ASI_S_OVR]));
      frm_r <= (rx_fin & ~rx_stop_ok)
               | (frm_r & ~(wr_stat & pwdata_in[`ASI_S_FRM]));
      per_r <= (rx_fin & serial_control_reg[`ASI_C_PAREN] & (^rx_sh_r ^ rx_par_r))
               | (per_r & ~(wr_stat & pwdata_in[`ASI_S_PER]));
    end
  end

  // ********************************
  // Group status and request outputs
  // ********************************
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      grp_r            <= 1'b0;
      rx_error_irq_out <= 1'b0;
      tx_end_irq_out   <= 1'b0;
      irq_out          <= 1'b0;
      tx_pin_out       <= 1'b1;
    end else begin
      grp_r            <= (ovr_r | frm_r | per_r) & serial_control_reg[`ASI_C_GRPEN];
      rx_error_irq_out <= grp_r;
      tx_end_irq_out   <= tx_end_flag_r & serial_control_reg[`ASI_C_TXEI];
      irq_out          <= |(stat & mask_r);
      tx_pin_out       <= serial_control_reg[`ASI_C_PINSEL] ? tx_line_r : 1'b1;
    end
  end

  assign rx_full_irq_out  = rxp_r;
  assign tx_empty_irq_out = txp_r;

  // ********************************
  // Assertions
  // ********************************
  a_rx_ack_clear: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (rx_full_irq_ack_in && !rx_set) |=> !rx_full_irq_out)
    else $error("receive pending flag not cleared by ack");

  a_tx_ack_clear: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (tx_empty_irq_ack_in && !tx_set) |=> !tx_empty_irq_out)
    else $error("transmit pending flag not cleared by ack");

  a_group_error: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    ((frm_r || ovr_r || per_r) && serial_control_reg[`ASI_C_GRPEN]
     && $stable(serial_control_reg)) |=> ##1 rx_error_irq_out)
    else $error("grouped error request missing");

  a_error_sticky: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (frm_r && !wr_stat) |=> frm_r)
    else $error("framing flag dropped without clear");

  a_tx_end_set: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (tx_done && !tx_full_r && !wr_data) |=> (tx_end_flag_r && tx_line_r))
    else $error("transmit end not flagged after stop bit");

  c_rx_byte: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    rx_fin && rx_stop_ok);
  c_tx_end: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    tx_done ##1 tx_end_flag_r);
  c_overrun: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    $rose(ovr_r));

endmodule

/* sim/asi_remote_station.sv */
// Remote serial station: frames bytes onto the channel input pin and
// decodes the frames that leave the channel output pin.
// Assumes BIT_CLKS system clocks per bit and a line idling high.
`timescale 1ns/1ps
module asi_remote_station #(
  parameter int BIT_CLKS = 16  // Clocks per bit
) (
  input  wire logic  clk_sys_in,    // System clock
  input  wire logic  line_in,       // Channel output pin
  output logic       line_out,      // Channel input pin
  output logic [8:0] frame_out,     // Stop bit, then data byte
  output logic       frame_vld_out  // One-cycle frame strobe
);
  logic [8:0] sh_r;  // Decoded bits, LSB first

  // ********************************
  // Frame sender
  // ********************************
  // One bit, changed just after an edge
  task automatic bit_out(input logic v);
    line_out <= v;
    repeat (BIT_CLKS) @(posedge clk_sys_in);
  endtask

  // Whole frame, faults only on request
  task automatic send(input logic [7:0] d, input logic par, input logic bad_par,
                      input logic bad_stop);
    @(posedge clk_sys_in);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) begin
      bit_out(d[i]);  // LSB first
    end
    if (par) begin
      bit_out(^d ^ bad_par);  // Even parity, flipped on request
    end
    bit_out(!bad_stop);  // Stop bit, low on request
    bit_out(1'b1);  // Idle bit before any next frame
  endtask

  // ********************************
  // Frame decoder
  // ********************************
  // Samples mid-bit from the start edge
  initial begin
    line_out = 1'b1;
    frame_out = 9'h000;
    frame_vld_out = 1'b0;
    forever begin
      @(negedge line_in);
      repeat (BIT_CLKS / 2) @(posedge clk_sys_in);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT_CLKS) @(posedge clk_sys_in);
        sh_r[i] = line_in;
      end
      frame_out <= sh_r;
      frame_vld_out <= 1'b1;
      @(posedge clk_sys_in);
      frame_vld_out <= 1'b0;
    end
  end
endmodule

/* sim/asi_testbench.sv */
// Self-checking bench: APB host, request acks, remote serial station.
// Assumes the defines header and the remote station model.
`timescale 1ns/1ps
`include "asi_defs.svh"
module testbench;
  logic        clk_sys_in;   // Clock
  logic        sys_rst_in;   // Reset
  logic        psel_in;      // APB select
  logic        penable_in;   // APB enable
  logic        pwrite_in;    // APB direction
  logic [7:0]  paddr_in;     // APB address
  logic [31:0] pwdata_in;    // APB write data
  logic [31:0] prdata_out;   // APB read data
  logic        pready_out;   // APB ready
  logic        pslverr_out;  // APB error
  logic        rx_pin_in;    // Remote to channel
  logic        tx_pin_out;   // Channel to remote
  logic        rx_ack_in;    // Receive taken
  logic        tx_ack_in;    // Transmit taken
  logic        rx_full_out;  // Receive-full
  logic        tx_empty_out; // Transmit-empty
  logic        rx_err_out;   // Grouped error
  logic        tx_end_out;   // Transmit-end
  logic        irq_out;      // Masked summary
  logic [8:0]  frame;        // Frame at remote
  logic        frame_vld;    // Frame strobe
  logic [32:0] exp_q[$];     // Expected reads
  logic [32:0] msk_q[$];     // Read masks
  logic [8:0]  tx_q[$];      // Expected frames
  logic [32:0] e_r;          // Popped note
  logic [32:0] m_r;          // Popped mask
  logic [31:0] rd_r;         // Last read
  logic [7:0]  seed_r = 8'h1E; // Random state
  logic [7:0]  b0;           // Test byte
  logic [7:0]  b1;           // Test byte
  logic [3:0]  rx_priority_level;    // Controller level, receive source
  logic [3:0]  error_priority_level; // Controller level, error source
  int          n_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;

  asi_serial_channel u_dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .rx_pin_in(rx_pin_in),
    .tx_pin_out(tx_pin_out), .rx_full_irq_ack_in(rx_ack_in),
    .tx_empty_irq_ack_in(tx_ack_in), .rx_full_irq_out(rx_full_out),
    .tx_empty_irq_out(tx_empty_out), .rx_error_irq_out(rx_err_out),
    .tx_end_irq_out(tx_end_out), .irq_out(irq_out));
  asi_remote_station #(.BIT_CLKS(16)) u_remote (.clk_sys_in(clk_sys_in),
    .line_in(tx_pin_out), .line_out(rx_pin_in), .frame_out(frame),
    .frame_vld_out(frame_vld));

  // ********************************
  // Helpers
  // ********************************
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic rnd(output logic [7:0] v);
    seed_r = lfsr(seed_r);
    v = seed_r;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Setup cycle, then access until ready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do @(posedge clk_sys_in); while (pready_out !== 1'b1);
    rd_r = prdata_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // Note the expected {pslverr, data} first
  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask

  // One-cycle ack, then let the clear land
  task automatic pulse(input logic rx);
    @(posedge clk_sys_in);
    rx_ack_in <= rx && rx_priority_level != 4'h0;  // Receive source taken only with a nonzero level
    tx_ack_in <= !rx;
    @(posedge clk_sys_in);
    rx_ack_in <= 1'b0;
    tx_ack_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ********************************
  // Output watchers and timeout
  // ********************************
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (psel_in && penable_in && !pwrite_in && pready_out === 1'b1) begin
      e_r = exp_q.pop_front();
      m_r = msk_q.pop_front();
      if (m_r != 33'h0) begin
        chk({pslverr_out, prdata_out} & m_r, e_r & m_r);
      end
    end
    if (frame_vld === 1'b1) begin
      chk({24'h0, frame}, {24'h0, tx_q.pop_front()});
    end
    if (cyc == 20000) begin
      n_errors++;
      $display("MISMATCH t=%0t run timed out", $time);
      end_of_test();
    end
  end

  // ********************************
  // Main sequence
  // ********************************
  initial begin
    sys_rst_in = 1'b1;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 8'h00;
    pwdata_in = 32'h0;
    rx_ack_in = 1'b0;
    tx_ack_in = 1'b0;
    repeat (20) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    rd(`ASI_OFF_CTRL, 33'h0, '1);
    rd(`ASI_OFF_STAT, 33'h4, '1);
    rd(`ASI_OFF_MASK, 33'h0, '1);
    rd(`ASI_OFF_BAUD, 33'h1, '1);
    wr(8'h14, 32'hFF);
    rd(8'h14, 33'h1_0000_0000, '1);
    rd(`ASI_OFF_CTRL, 33'h0, '1);
    $display("test reset done");
    wr(`ASI_OFF_BAUD, 32'h0);
    rd(`ASI_OFF_BAUD, 33'h0, '1);
    rx_priority_level = 4'h5;
    error_priority_level = 4'h5;
    repeat (16) @(posedge clk_sys_in);
    wr(`ASI_OFF_CTRL, 32'h6F);
    repeat (3) @(posedge clk_sys_in);
    chk(tx_empty_out, 1);
    pulse(1'b0);
    chk(tx_empty_out, 0);
    rnd(b0);
    rnd(b1);
    tx_q.push_back({1'b1, b0});
    tx_q.push_back({1'b1, b1});
    wr(`ASI_OFF_DATA, {24'h0, b0});
    repeat (4) @(posedge clk_sys_in);
    chk(tx_empty_out, 1);
    pulse(1'b0);
    chk(tx_empty_out, 0);
    wr(`ASI_OFF_DATA, {24'h0, b1});
    repeat (3) @(posedge clk_sys_in);
    chk(tx_empty_out, 0);
    rd(`ASI_OFF_STAT, 33'h0, 33'h4);
    for (int i = 0; i < 300 && rd_r[`ASI_S_TX_END_FLAG] !== 1'b1; i++) begin
      rd(`ASI_OFF_STAT, 33'h0, 33'h0);
    end
    chk(rd_r[`ASI_S_TX_END_FLAG], 1);
    chk(tx_q.size(), 0);
    wr(`ASI_OFF_CTRL, 32'h75);
    wr(`ASI_OFF_STAT, 32'h2);
    repeat (3) @(posedge clk_sys_in);
    chk(tx_end_out, 1);
    wr(`ASI_OFF_CTRL, 32'h25);
    repeat (3) @(posedge clk_sys_in);
    chk(tx_end_out, 0);
    chk(tx_pin_out, 1);
    $display("test transmit done");
    wr(`ASI_OFF_MASK, 32'h1);
    rnd(b0);
    u_remote.send(b0, 1'b0, 1'b0, 1'b0);
    chk(rx_full_out, 1);
    chk(irq_out, 1);
    wr(`ASI_OFF_MASK, 32'h0);
    repeat (3) @(posedge clk_sys_in);
    chk(irq_out, 0);
    wr(`ASI_OFF_MASK, 32'h1);
    pulse(1'b1);
    repeat (2) @(posedge clk_sys_in);
    chk(rx_full_out, 0);
    chk(irq_out, 0);
    rd(`ASI_OFF_DATA, {25'h0, b0}, '1);
    $display("test receive done");
    wr(`ASI_OFF_CTRL, 32'h21);
    rnd(b1);
    u_remote.send(b1, 1'b0, 1'b0, 1'b0);
    chk(rx_full_out, 0);
    rd(`ASI_OFF_DATA, {25'h0, b1}, '1);
    u_remote.send(b1, 1'b0, 1'b0, 1'b1);
    rd(`ASI_OFF_STAT, 33'h54, 33'h7D);
    chk(rx_err_out & (error_priority_level == 4'h5), 1);
    rd(`ASI_OFF_DATA, 33'h0, 33'h0);
    wr(`ASI_OFF_STAT, 32'h10);
    repeat (3) @(posedge clk_sys_in);
    chk(rx_err_out, 0);
    wr(`ASI_OFF_CTRL, 32'h81);
    u_remote.send(b1, 1'b1, 1'b1, 1'b0);
    rd(`ASI_OFF_STAT, 33'h24, 33'h7D);
    chk(rx_err_out, 0);
    rd(`ASI_OFF_DATA, 33'h0, 33'h0);
    wr(`ASI_OFF_STAT, 32'h20);
    wr(`ASI_OFF_CTRL, 32'hA1);
    rnd(b0);
    u_remote.send(b0, 1'b1, 1'b0, 1'b0);
    u_remote.send(b1, 1'b1, 1'b0, 1'b0);
    rd(`ASI_OFF_STAT, 33'h4C, 33'h7D);
    rd(`ASI_OFF_DATA, {25'h0, b0}, '1);
    wr(`ASI_OFF_CTRL, 32'h0);
    wr(`ASI_OFF_STAT, 32'h7F);
    rd(`ASI_OFF_STAT, 33'h4, '1);
    $display("test receive errors done");
    end_of_test();
  end
endmodule
